// *** hw/nvmac_pkg.sv ***
package nvmac_pkg;

   // register byte addresses on the bus
   localparam logic [7:0] ADDR_DATA    = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_ADDRESS = 8'h08;
   localparam logic [7:0] ADDR_STATUS  = 8'h0C;
   localparam logic [7:0] ADDR_MASK    = 8'h10;
   localparam logic [7:0] ADDR_GIE     = 8'h14;

   // control register fields
   localparam int CTL_READ   = 0;
   localparam int CTL_PROG   = 1;
   localparam int CTL_MASTER = 2;
   localparam int CTL_RDYIE  = 3;
   localparam int CTL_MODELO = 4;
   localparam int CTL_MODEHI = 5;

   // event bits in status and mask
   localparam int EV_PROGDONE = 0;
   localparam int EV_READDONE = 1;
   localparam int EV_IGNORED  = 2;

   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam int         ADDR_W     = 9;
   localparam int         DEPTH      = 512;

   localparam logic [1:0] MODE_ATOMIC = 2'h0;
   localparam logic [1:0] MODE_ERASE  = 2'h1;
   localparam logic [1:0] MODE_WRITE  = 2'h2;

   // programming times in microseconds, clock 100 MHz
   localparam int CLK_MHZ        = 100;
   localparam int T_ATOMIC_US    = 3400;
   localparam int T_SPLIT_US     = 1800;
   localparam int ATOMIC_CYCLES  = T_ATOMIC_US * CLK_MHZ;
   localparam int SPLIT_CYCLES   = T_SPLIT_US * CLK_MHZ;
   localparam logic [2:0] MASTER_HOLD = 3'h4;

   typedef enum logic [2:0] {
      NVMAC_IDLE = 3'b001,
      NVMAC_PROG = 3'b010,
      NVMAC_READ = 3'b100
   } nvmac_state_t;

endpackage : nvmac_pkg

// *** hw/nvmac_array.sv ***
`timescale 1ns/1ps
module nvmac_array
   import nvmac_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              eraseEn,
   input  wire logic              writeEn,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   output logic      [7:0]        rdata
);
   // erased cells read all ones; write only clears bits
   logic [7:0] cells [DEPTH];

   always_ff @(posedge clk)
   begin
      if (eraseEn && writeEn)
         cells[addr] <= wdata;
      else if (eraseEn)
         cells[addr] <= 8'hFF;
      else if (writeEn)
         cells[addr] <= cells[addr] & wdata;
      rdata <= cells[addr];
   end
endmodule : nvmac_array

// *** hw/nvmac_timer.sv ***
`timescale 1ns/1ps
module nvmac_timer
   import nvmac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        start,
   input  wire logic [31:0] load,
   output logic             done
);
   typedef struct packed {
      logic [31:0] count;
      logic        run;
      logic        done;
   } nvmac_tim_t;

   nvmac_tim_t s_reg;
   nvmac_tim_t s_next;

   always_comb
   begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (start)
      begin
         s_next.count = load;
         s_next.run = 1'b1;
      end
      else if (s_reg.run)
      begin
         if (s_reg.count <= 32'h1)
         begin
            s_next.run = 1'b0;
            s_next.done = 1'b1;
         end
         else
            s_next.count = s_reg.count - 32'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign done = s_reg.done;
endmodule : nvmac_timer

// *** hw/nvmac_top.sv ***
`timescale 1ns/1ps
module nvmac_top
   import nvmac_pkg::*;
#(
   parameter int ATOMIC_TIME = ATOMIC_CYCLES,
   parameter int SPLIT_TIME  = SPLIT_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   output logic             readyIrq
);
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      nvmac_state_t          state;
      logic [7:0]            data;
      logic [ADDR_W-1:0]     address;
      logic [1:0]            mode;
      logic                  rdyIe;
      logic                  master;
      logic [2:0]            masterCnt;
      logic                  prog;
      logic                  read;
      logic [2:0]            status;
      logic [2:0]            mask;
      logic                  gie;
      logic                  wrPend;
      logic [7:0]            wrAddr;
      logic [31:0]           rdata;
      logic                  irq;
      logic                  readyIrq;
   } nvmac_regs_t;

   nvmac_regs_t s_reg;
   nvmac_regs_t s_next;

   logic        timerStart;
   logic [31:0] timerLoad;
   logic        timerDone;
   logic        eraseEn;
   logic        writeEn;
   logic [7:0]  arrayData;

   function automatic logic [31:0] readMux(input nvmac_regs_t s,
                                           input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0;
      if (a == ADDR_DATA)
         v = {24'h0, s.data};
      else if (a == ADDR_CONTROL)
         v = {24'h0, 2'h0, s.mode, s.rdyIe, s.master, s.prog, s.read};
      else if (a == ADDR_ADDRESS)
         v = {23'h0, s.address};
      else if (a == ADDR_STATUS)
         v = {29'h0, s.status};
      else if (a == ADDR_MASK)
         v = {29'h0, s.mask};
      else if (a == ADDR_GIE)
         v = {31'h0, s.gie};
      return v;
   endfunction : readMux

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic       addrPhase;
      logic [7:0] wv;
      logic [2:0] ev;
      s_next     = s_reg;
      addrPhase  = hsel && htrans[1] && hready;
      wv         = hwdata[7:0];
      ev         = 3'h0;
      timerStart = 1'b0;
      timerLoad  = 32'(SPLIT_TIME);
      eraseEn    = 1'b0;
      writeEn    = 1'b0;

      // master window counts down and self-clears
      if (s_reg.master)
      begin
         if (s_reg.masterCnt <= 3'h1)
            s_next.master = 1'b0;
         else
            s_next.masterCnt = s_reg.masterCnt - 3'h1;
      end

      // register writes land in the data phase
      if (s_reg.wrPend)
      begin
         if (s_reg.wrAddr == ADDR_DATA)
            s_next.data = wv;
         else if (s_reg.wrAddr == ADDR_ADDRESS)
            s_next.address = hwdata[ADDR_W-1:0];
         else if (s_reg.wrAddr == ADDR_MASK)
            s_next.mask = hwdata[2:0];
         else if (s_reg.wrAddr == ADDR_GIE)
            s_next.gie = hwdata[0];
         else if (s_reg.wrAddr == ADDR_STATUS)
            s_next.status = s_reg.status & ~hwdata[2:0];
         else if (s_reg.wrAddr == ADDR_CONTROL)
         begin
            s_next.rdyIe = wv[CTL_RDYIE];
            if (!s_reg.prog)
               s_next.mode = wv[CTL_MODEHI:CTL_MODELO];
            if (wv[CTL_MASTER])
            begin
               s_next.master    = 1'b1;
               s_next.masterCnt = MASTER_HOLD;
            end
            // strobe honoured only inside the window and when idle
            if (wv[CTL_PROG] && !s_reg.prog)
            begin
               if (s_reg.master && s_reg.state == NVMAC_IDLE
                   && s_reg.mode != 2'h3)
               begin
                  s_next.prog  = 1'b1;
                  s_next.state = NVMAC_PROG;
                  timerStart   = 1'b1;
                  timerLoad    = (s_reg.mode == MODE_ATOMIC) ?
                                 32'(ATOMIC_TIME) : 32'(SPLIT_TIME);
                  eraseEn = (s_reg.mode != MODE_WRITE);
                  writeEn = (s_reg.mode != MODE_ERASE);
                  s_next.master = 1'b0;
               end
               else
                  ev[EV_IGNORED] = 1'b1;
            end
            // read strobe ignored during programming
            if (wv[CTL_READ] && s_reg.state == NVMAC_IDLE
                && !(wv[CTL_PROG] && s_reg.master))
            begin
               s_next.read  = 1'b1;
               s_next.state = NVMAC_READ;
            end
         end
      end

      case (s_reg.state)
         NVMAC_PROG:
         begin
            if (timerDone)
            begin
               s_next.prog  = 1'b0;
               s_next.state = NVMAC_IDLE;
               ev[EV_PROGDONE] = 1'b1;
            end
         end
         NVMAC_READ:
         begin
            // array output valid one cycle after address
            s_next.data  = arrayData;
            s_next.read  = 1'b0;
            s_next.state = NVMAC_IDLE;
            ev[EV_READDONE] = 1'b1;
         end
         default:
         begin
         end
      endcase

      // set wins over a same-cycle clear
      s_next.status = s_next.status | ev;

      s_next.wrPend = addrPhase && hwrite;
      if (addrPhase)
      begin
         s_next.wrAddr = haddr[7:0];
         if (!hwrite)
            s_next.rdata = readMux(s_reg, haddr[7:0]);
      end

      s_next.readyIrq = s_next.rdyIe && s_next.gie && !s_next.prog;
      s_next.irq = |(s_next.status & s_next.mask);
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s_reg.state     <= NVMAC_IDLE;
         s_reg.data      <= DATA_RESET;
         s_reg.address   <= '0;
         s_reg.rdyIe     <= 1'b0;
         s_reg.master    <= 1'b0;
         s_reg.masterCnt <= 3'h0;
         s_reg.read      <= 1'b0;
         s_reg.status    <= 3'h0;
         s_reg.mask      <= 3'h0;
         s_reg.gie       <= 1'b0;
         s_reg.wrPend    <= 1'b0;
         s_reg.wrAddr    <= 8'h0;
         s_reg.rdata     <= 32'h0;
         s_reg.irq       <= 1'b0;
         s_reg.readyIrq  <= 1'b0;
         // a running program survives reset; mode held too
         if (s_reg.prog)
         begin
            s_reg.prog  <= s_next.prog;
            s_reg.mode  <= s_reg.mode;
            s_reg.state <= s_next.prog ? NVMAC_PROG : NVMAC_IDLE;
         end
         else
         begin
            s_reg.prog <= 1'b0;
            s_reg.mode <= MODE_RESET;
         end
      end
      else
         s_reg <= s_next;
   end

   ////////////////////////////////////////////////////////////////////
   nvmac_array u_array (
      .clk     (clk),
      .eraseEn (eraseEn),
      .writeEn (writeEn),
      .addr    (s_reg.address),
      .wdata   (s_reg.data),
      .rdata   (arrayData)
   );

   // timer keeps running through reset so programming can finish
   nvmac_timer u_timer (
      .clk   (clk),
      .reset (1'b0),
      .start (timerStart),
      .load  (timerLoad),
      .done  (timerDone)
   );

   assign hrdata    = s_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = s_reg.irq;
   assign readyIrq  = s_reg.readyIrq;
endmodule : nvmac_top

// *** tb/nvmac_properties.sv ***
`timescale 1ns/1ps
module nvmac_properties
   import nvmac_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        irq,
   input wire logic        readyIrq
);
   logic       wrPend_reg;
   logic [7:0] wrAddr_reg;
   logic       rdReq;
   assign rdReq = hsel && htrans[1] && hready && !hwrite;
   // write data lags its address by one cycle
   always_ff @(posedge clk)
   begin
      wrPend_reg <= !reset && hsel && htrans[1] && hready && hwrite;
      wrAddr_reg <= haddr[7:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_ready_always: assert property (hreadyout) else $error("wait state");
   a_resp_okay: assert property (!hresp) else $error("error response");
   a_reset_quiet: assert property ($fell(reset) |-> !irq && !readyIrq)
      else $error("interrupt after reset");
   a_ctl_reserved: assert property (rdReq && haddr == 32'h4
      |=> hrdata[31:6] == 26'h0) else $error("control top bits set");
   a_data_byte: assert property (rdReq && haddr == 32'h0
      |=> hrdata[31:8] == 24'h0) else $error("data upper bits set");
   a_unmapped_zero: assert property (rdReq && haddr == 32'h18
      |=> hrdata == 32'h0) else $error("unmapped read not zero");
   a_gie_off: assert property (wrPend_reg && wrAddr_reg == ADDR_GIE
      && !hwdata[0] |-> ##[1:2] !readyIrq) else $error("ready irq stuck");
   a_mask_off: assert property (wrPend_reg && wrAddr_reg == ADDR_MASK
      && hwdata[2:0] == 3'h0 |-> ##[1:2] !irq) else $error("irq stuck");
   cover property (rdReq && haddr == 32'h4);
   cover property ($rose(readyIrq));
   cover property ($rose(irq));
endmodule : nvmac_properties
////////////////////////////////////////////////////////////////////////////
bind nvmac_top nvmac_properties u_props (.clk(clk), .reset(reset),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .readyIrq(readyIrq));

// *** tb/nvmac_tb.sv ***
`timescale 1ns/1ps
module nvmac_tb
   import nvmac_pkg::*;
;
   localparam int LIMIT = 20000;
   logic        clk, reset, hsel, hwrite, hready, dataRd;
   logic        hreadyout, hresp, irq, readyIrq;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0]  htrans, mode;
   logic [2:0]  hsize;
   logic [31:0] expQ[$];
   int          n_fail, n_compared, cyc, seed;
   initial clk = 1'b0;
   always #5 clk = ~clk;
   assign hready = hreadyout;
   // short programming times keep the run small
   // split time long enough that programming outlives a mid-run reset
   nvmac_top #(.ATOMIC_TIME(20), .SPLIT_TIME(16)) DUT (.clk(clk),
      .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .readyIrq(readyIrq));
////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, wr, 24'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      {hsel, htrans, hwdata, dataRd} <= {3'h0, v, !wr};
      do @(posedge clk); while (hready !== 1'b1);
      dataRd <= 1'b0;
   endtask : xfer
   task rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      xfer(1'b0, a, $random(seed));
   endtask : rd
   task settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task finish_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
      if (dataRd === 1'b1 && hready === 1'b1)
         check(hrdata, expQ.pop_front());
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         n_fail++;
         finish_test();
      end
   end
   initial
   begin
      {seed, n_fail, n_compared, cyc} = {32'd1, 96'd0};
      {reset, hsel, htrans, hwrite, hsize, dataRd} = 9'h104;
      {haddr, hwdata} = 64'h0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rd(ADDR_DATA, 32'h0);
      rd(ADDR_CONTROL, 32'h0);
      xfer(1'b1, 8'h18, 32'hFFFFFFFF);
      rd(8'h18, 32'h0);
      $display("test 1 done");
      repeat (4)
      begin
         d = $random(seed);
         xfer(1'b1, ADDR_DATA, d);
         rd(ADDR_DATA, {24'h0, d[7:0]});
      end
      $display("test 2 done");
      xfer(1'b1, ADDR_CONTROL, 32'h4);
      repeat (6) @(posedge clk);
      rd(ADDR_CONTROL, 32'h0);
      xfer(1'b1, ADDR_CONTROL, 32'h2);
      xfer(1'b1, ADDR_CONTROL, 32'h34);
      xfer(1'b1, ADDR_CONTROL, 32'h32);
      repeat (6) @(posedge clk);
      rd(ADDR_CONTROL, 32'h30);
      rd(ADDR_STATUS, 32'h4);
      $display("test 4 done");
      for (mode = MODE_ATOMIC; mode != 2'h3; mode++)
      begin
         d = $random(seed);
         xfer(1'b1, ADDR_ADDRESS, 32'h1A5);
         xfer(1'b1, ADDR_DATA, d);
         xfer(1'b1, ADDR_CONTROL, {26'h0, mode, 4'h4});
         xfer(1'b1, ADDR_CONTROL, {26'h0, mode, 4'h2});
         rd(ADDR_CONTROL, {26'h0, mode, 4'h2});
         xfer(1'b1, ADDR_CONTROL, {26'h0, ~mode, 4'h2});
         rd(ADDR_CONTROL, {26'h0, mode, 4'h2});
         if (mode == MODE_ERASE)
         begin
            reset <= 1'b1;
            repeat (2) @(posedge clk);
            reset <= 1'b0;
            rd(ADDR_CONTROL, {26'h0, mode, 4'h2});
         end
         repeat (40) @(posedge clk);
         rd(ADDR_CONTROL, {26'h0, mode, 4'h0});
         xfer(1'b1, ADDR_ADDRESS, 32'h1A5);
         xfer(1'b1, ADDR_CONTROL, {26'h0, mode, 4'h1});
         settle();
         rd(ADDR_DATA, mode == MODE_ERASE ? 32'hFF : {24'h0, d[7:0]});
      end
      $display("test 5 done");
      // cells power up unknown; last pass left d at 0x1A5
      xfer(1'b1, ADDR_STATUS, 32'h7);
      xfer(1'b1, ADDR_DATA, 32'h0);
      xfer(1'b1, ADDR_ADDRESS, 32'h1A5);
      xfer(1'b1, ADDR_CONTROL, 32'h1);
      settle();
      rd(ADDR_CONTROL, 32'h0);
      rd(ADDR_DATA, {24'h0, d[7:0]});
      rd(ADDR_STATUS, 32'h2);
      $display("test 3 done");
      xfer(1'b1, ADDR_STATUS, 32'h7);
      xfer(1'b1, ADDR_GIE, 32'h1);
      xfer(1'b1, ADDR_MASK, 32'h1);
      xfer(1'b1, ADDR_CONTROL, 32'hC);
      xfer(1'b1, ADDR_CONTROL, 32'hA);
      settle();
      check({31'h0, readyIrq}, 32'h0);
      repeat (40) @(posedge clk);
      settle();
      check({31'h0, readyIrq}, 32'h1);
      check({31'h0, irq}, 32'h1);
      xfer(1'b1, ADDR_MASK, 32'h0);
      settle();
      check({31'h0, irq}, 32'h0);
      xfer(1'b1, ADDR_STATUS, 32'h1);
      xfer(1'b1, ADDR_MASK, 32'h1);
      settle();
      check({31'h0, irq}, 32'h0);
      xfer(1'b1, ADDR_GIE, 32'h0);
      settle();
      check({31'h0, readyIrq}, 32'h0);
      $display("test 6 done");
      finish_test();
   end
endmodule : nvmac_tb
